// ### hdl/rfas_pkg.sv
package rfas_pkg;

    // Management access widths
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Register indices on the management access port
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_STAT = 5'h01;
    localparam logic [4:0] A_CNT  = 5'h02;
    localparam logic [4:0] A_CFG  = 5'h03;

    // Control register field positions
    localparam int CTRL_SRST_BIT = 15;
    localparam int CTRL_FUNC_BIT = 14;
    localparam int CTRL_WO_LSB   = 12;
    localparam int CTRL_UPD_LSB  = 8;
    localparam int CTRL_RW_LSB   = 0;

    // Status register field positions
    localparam int STAT_LH_BIT   = 0;
    localparam int STAT_LL_BIT   = 1;
    localparam int STAT_LIVE_BIT = 2;

    // Configuration register field positions
    localparam int CFG_RET_LSB = 8;
    localparam int CFG_RWC_LSB = 0;

    // Values after reset, and the saturation value of the counter
    localparam logic [7:0]  RW_INIT  = 8'h01;
    localparam logic [3:0]  UPD_INIT = 4'h0;
    localparam logic [1:0]  WO_INIT  = 2'h0;
    localparam logic [7:0]  RET_INIT = 8'h00;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;

    // Duration of the self-clearing function
    localparam int CLK_MHZ      = 250;
    localparam int FUNC_TIME_NS = 40;
    localparam int FUNC_CYCLES  = (FUNC_TIME_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] FUNC_LAST = 8'(FUNC_CYCLES - 1);

    // One management access, taken in a single cycle
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [4:0]        addr;
        logic [15:0]       wdata;
    } rfas_req_s;

    // Whole register state of the bank
    typedef struct packed {
        logic [7:0]  rw;
        logic [3:0]  upd_pend;
        logic [3:0]  upd_act;
        logic [1:0]  wo;
        logic        func_busy;
        logic [7:0]  func_cnt;
        logic        soft_pend;
        logic        lh;
        logic        ll;
        logic [15:0] cnt;
        logic [7:0]  ret;
        logic [7:0]  read_write_clear_field;
        logic [15:0] rdata;
        logic        rvalid;
    } rfas_state_s;

endpackage : rfas_pkg

// ### hdl/rfas_bank.sv
`timescale 1ns/1ps
`default_nettype none

module rfas_bank
    import rfas_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ce,
    input  wire rfas_req_s   i_req,
    input  wire logic        i_lh_cond,
    input  wire logic        i_ll_cond,
    input  wire logic        i_cnt_event,
    output logic [15:0]      o_rdata,
    output logic             o_rvalid,
    output logic [7:0]       o_rw_cfg,
    output logic [3:0]       o_upd_cfg,
    output logic [1:0]       o_wo_cfg,
    output logic [7:0]       o_ret_cfg,
    output logic             o_func_busy,
    output logic             o_soft_rst
);

    logic        rst_meta;
    logic        rst_n;
    rfas_state_s r;
    rfas_state_s next_r;

    // Reset release through two flops so every state flop leaves reset on the same edge
    // The pin drops the bank at once; only the release is made synchronous
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Read data as seen by the station; unused positions stay zero
    function automatic logic [15:0] read_mux(input rfas_state_s s, input logic [4:0] a);
        logic [15:0] d;
        d = 16'h0000;
        unique case (a)
            A_CTRL: begin
                // Soft reset bit clears itself, so software always reads it as zero
                d[CTRL_SRST_BIT]              = 1'b0;
                d[CTRL_FUNC_BIT]              = s.func_busy;
                d[CTRL_UPD_LSB +: 4]          = s.upd_pend;
                d[CTRL_RW_LSB +: 8]           = s.rw;
                // Write-only bits read as zero, which is one legal undefined value
                d[CTRL_WO_LSB +: 2]           = 2'h0;
            end
            A_STAT: begin
                d[STAT_LH_BIT]   = s.lh;
                d[STAT_LL_BIT]   = s.ll;
                // Spare status position, held at zero like the reserved bits
                d[STAT_LIVE_BIT] = 1'b0;
            end
            A_CNT: begin
                // Full count goes out; the clear happens in the next-state logic
                d = s.cnt;
            end
            A_CFG: begin
                d[CFG_RET_LSB +: 8] = s.ret;
                d[CFG_RWC_LSB +: 8] = s.read_write_clear_field;
            end
            default: begin
                d = 16'h0000;
            end
        endcase
        return d;
    endfunction : read_mux

    // Next state: soft reset, then read clears, then writes, then hardware sets win last
    // A hardware event landing in the cycle of its clear must survive, otherwise
    // a short fault between two reads would go unseen
    always_comb begin
        logic        rd_stat;
        logic        rd_cnt;
        logic        rd_cfg;
        logic        wr_ctrl;
        logic        wr_cfg;
        logic [15:0] cnt_base;
        rd_stat  = i_req.rd && (i_req.addr == A_STAT);
        rd_cnt   = i_req.rd && (i_req.addr == A_CNT);
        rd_cfg   = i_req.rd && (i_req.addr == A_CFG);
        wr_ctrl  = i_req.wr && (i_req.addr == A_CTRL);
        wr_cfg   = i_req.wr && (i_req.addr == A_CFG);
        cnt_base = r.cnt;
        next_r   = r;
        next_r.rvalid    = 1'b0;
        next_r.soft_pend = 1'b0;

        // Soft reset: rw and the clear-on-read fields reload (wo and the function are kept), deferred value goes live
        if (r.soft_pend) begin
            next_r.rw      = RW_INIT;
            next_r.upd_act = r.upd_pend;
            next_r.read_write_clear_field     = 8'h00;
            next_r.lh      = 1'b0;
            next_r.ll      = 1'b1;
            cnt_base       = 16'h0000;
            // ret and upd_pend are left alone across a soft reset
            next_r.ret     = r.ret;
            next_r.upd_pend = r.upd_pend;
        end

        // Read answer and clear-on-read side effects
        // A read beside a write returns the value from before the write
        if (i_req.rd) begin
            next_r.rvalid = 1'b1;
            next_r.rdata  = read_mux(r, i_req.addr);
        end
        if (rd_stat) begin
            next_r.lh = 1'b0;
            next_r.ll = 1'b1;
        end
        if (rd_cnt) begin
            cnt_base = 16'h0000;
        end
        if (rd_cfg) begin
            next_r.read_write_clear_field = 8'h00;
        end

        // Writes; status and counter addresses ignore them
        // A write in the cycle a soft reset applies lands after it and wins
        if (wr_ctrl) begin
            next_r.rw       = i_req.wdata[CTRL_RW_LSB +: 8];
            next_r.upd_pend = i_req.wdata[CTRL_UPD_LSB +: 4];
            next_r.wo       = i_req.wdata[CTRL_WO_LSB +: 2];
            next_r.soft_pend = i_req.wdata[CTRL_SRST_BIT];
            // A go written while busy is ignored, so a running count is never cut short
            if (i_req.wdata[CTRL_FUNC_BIT] && !r.func_busy) begin
                next_r.func_busy = 1'b1;
                next_r.func_cnt  = FUNC_LAST;
            end
        end
        if (wr_cfg) begin
            next_r.ret = i_req.wdata[CFG_RET_LSB +: 8];
            next_r.read_write_clear_field = i_req.wdata[CFG_RWC_LSB +: 8];
        end

        // Self-clearing function counts down and drops its bit when finished
        if (r.func_busy) begin
            if (r.func_cnt == 8'h00) begin
                next_r.func_busy = 1'b0;
            end else begin
                next_r.func_cnt = r.func_cnt - 8'h01;
            end
        end

        // Conditions seen in the clearing cycle are kept, so no event is lost
        if (i_lh_cond) begin
            next_r.lh = 1'b1;
        end
        if (!i_ll_cond) begin
            next_r.ll = 1'b0;
        end

        // Saturate rather than wrap, so a burst between reads never shows as a small count
        if (i_cnt_event && (cnt_base != CNT_MAX)) begin
            next_r.cnt = cnt_base + 16'h0001;
        end else begin
            next_r.cnt = cnt_base;
        end

        // Clock enable low freezes the whole bank
        // The reset synchroniser sits outside this process and keeps running
        if (!i_ce) begin
            next_r = r;
        end
    end

    // State register; hardware reset loads every field including retained ones
    // Only constants in the reset branch; release timing comes from the synchroniser
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r.rw        <= RW_INIT;
            r.upd_pend  <= UPD_INIT;
            r.upd_act   <= UPD_INIT;
            r.wo        <= WO_INIT;
            r.func_busy <= 1'b0;
            r.func_cnt  <= 8'h00;
            r.soft_pend <= 1'b0;
            r.lh        <= 1'b0;
            r.ll        <= 1'b1;
            r.cnt       <= 16'h0000;
            r.ret       <= RET_INIT;
            r.read_write_clear_field       <= 8'h00;
            r.rdata     <= 16'h0000;
            r.rvalid    <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs come straight from the state flops
    // Nothing here is decoded, so the station never sees a glitch
    assign o_rdata     = r.rdata;
    assign o_rvalid    = r.rvalid;
    assign o_rw_cfg    = r.rw;
    assign o_upd_cfg   = r.upd_act;
    assign o_wo_cfg    = r.wo;
    assign o_ret_cfg   = r.ret;
    assign o_func_busy = r.func_busy;
    assign o_soft_rst  = r.soft_pend;

endmodule : rfas_bank

`default_nettype wire

// ### tb/rfas_station.sv
`timescale 1ns/1ps
`default_nettype none
module rfas_station
    import rfas_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rvalid,
    output var rfas_req_s    o_req
);
    // Idle between accesses so no stray read consumes a clear-on-read field
    initial o_req = '0;
    // One access: held over its taking edge, answer picked up just after it
    task xfer(input logic rd, input logic wr, input logic [4:0] a, input logic [15:0] d,
              output logic [15:0] q);
        @(posedge i_ref_clk);
        #1 o_req = '{rd, wr, a, d};
        @(posedge i_ref_clk);
        #1 q = i_rvalid ? i_rdata : 16'hxxxx;
        o_req = '0;
    endtask : xfer
endmodule : rfas_station
`default_nettype wire

// ### tb/rfas_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rfas_bank_properties
    import rfas_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_nrst,
    input wire logic        i_ce,
    input wire rfas_req_s   i_req,
    input wire logic [15:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic [7:0]  o_rw_cfg,
    input wire logic [3:0]  o_upd_cfg,
    input wire logic [1:0]  o_wo_cfg,
    input wire logic [7:0]  o_ret_cfg,
    input wire logic        o_func_busy,
    input wire logic        o_soft_rst
);
    // Single clock domain
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    logic wr_ctl;
    // Plain control write, soft reset bit left out since it reloads fields
    assign wr_ctl = i_ce && i_req.wr && i_req.addr == A_CTRL && !i_req.wdata[CTRL_SRST_BIT];
    read_answer_a: assert property (i_ce && i_req.rd |=> o_rvalid)
        else $error("read not answered");
    stat_resv_a: assert property (i_ce && i_req.rd && i_req.addr == A_STAT
        |=> o_rdata[15:2] == 14'h0000) else $error("reserved bits not zero");
    rw_store_a: assert property (wr_ctl |=> o_rw_cfg == $past(i_req.wdata[7:0]))
        else $error("field not stored");
    wo_store_a: assert property (wr_ctl |=> o_wo_cfg == $past(i_req.wdata[13:12]))
        else $error("write-only field not stored");
    // A go while already busy is ignored, so only an idle start is demanded
    func_go_a: assert property (wr_ctl && !o_func_busy && i_req.wdata[CTRL_FUNC_BIT]
        |=> o_func_busy) else $error("function not started");
    // Busy stands for exactly the function's cycle count, then drops by itself
    func_len_a: assert property ($rose(o_func_busy) |-> o_func_busy[*8] ##1 o_func_busy[*2]
        ##1 !o_func_busy) else $error("function length wrong");
    upd_hold_a: assert property (!o_soft_rst |=> $stable(o_upd_cfg))
        else $error("deferred field changed early");
    ret_keep_a: assert property (o_soft_rst && !(i_ce && i_req.wr)
        |=> $stable(o_ret_cfg)) else $error("retained field lost");
    soft_init_a: assert property (o_soft_rst && !(i_ce && i_req.wr)
        |=> o_rw_cfg == RW_INIT) else $error("field not reloaded");
endmodule : rfas_bank_properties
bind rfas_bank rfas_bank_properties chk_u (.i_ref_clk, .i_nrst, .i_ce, .i_req, .o_rdata,
    .o_rvalid, .o_rw_cfg, .o_upd_cfg, .o_wo_cfg, .o_ret_cfg, .o_func_busy, .o_soft_rst);
`default_nettype wire

// ### tb/rfas_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rfas_bank_bench
    import rfas_pkg::*;
;
    logic        clk, nrst, ce, lh, ll, ev, rv, busy, srst;
    rfas_req_s   req;
    logic [15:0] rdat, q;
    logic [7:0]  rw, ret;
    logic [3:0]  upd;
    logic [1:0]  wo;
    int          n_errors = 0, comparisons = 0;
    rfas_bank dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_req(req),
        .i_lh_cond(lh), .i_ll_cond(ll), .i_cnt_event(ev), .o_rdata(rdat), .o_rvalid(rv),
        .o_rw_cfg(rw), .o_upd_cfg(upd), .o_wo_cfg(wo), .o_ret_cfg(ret),
        .o_func_busy(busy), .o_soft_rst(srst));
    rfas_station st_u (.i_ref_clk(clk), .i_rdata(rdat), .i_rvalid(rv), .o_req(req));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [4:0] a);
        st_u.xfer(1'b1, 1'b0, a, 16'h0000, q);
    endtask : rd
    task wr(input logic [4:0] a, input logic [15:0] d);
        st_u.xfer(1'b0, 1'b1, a, d, q);
    endtask : wr
    // Hardware reset, then wait out the release synchroniser
    task hw_rst();
        #1 nrst = 1'b0;
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clk);
    endtask : hw_rst
    task t_rw();
        rd(A_CTRL); chk(q, 16'h0001);
        wr(A_CTRL, 16'h30A5); rd(A_CTRL); chk(q & 16'hCFFF, 16'h00A5);
        chk({14'h0000, wo}, 16'h0003);
        wr(A_CFG, 16'h5A3C); rd(A_CFG); chk(q, 16'h5A3C);
        rd(A_CFG); chk(q, 16'h5A00);
        rd(5'h1F); chk(q, 16'h0000);
    endtask : t_rw
    // Short glitches on both conditions must be caught and then read away
    task t_latch();
        @(posedge clk); #1 lh = 1'b1; ll = 1'b0;
        @(posedge clk); #1 lh = 1'b0; ll = 1'b1;
        rd(A_STAT); chk(q, 16'h0001);
        rd(A_STAT); chk(q, 16'h0002);
    endtask : t_latch
    task t_cnt();
        wr(A_CNT, 16'h1234);
        @(posedge clk); #1 ev = 1'b1;
        repeat (3) @(posedge clk); #1 ev = 1'b0;
        rd(A_CNT); chk(q, 16'h0003);
        rd(A_CNT); chk(q, 16'h0000);
        @(posedge clk); #1 ev = 1'b1;
        repeat (65540) @(posedge clk); #1 ev = 1'b0;
        rd(A_CNT); chk(q, CNT_MAX);
    endtask : t_cnt
    // Clock enable low: a write with the go bit set must leave rw and the function busy bit as they were
    task t_ce();
        @(posedge clk);
        #1 ce = 1'b0;
        wr(A_CTRL, 16'h4055);
        ce = 1'b1;
        chk({8'h00, rw}, 16'h00A5);
        chk({15'h0000, busy}, 16'h0000);
    endtask : t_ce
    task t_func();
        wr(A_CTRL, 16'h4000); chk({15'h0000, busy}, 16'h0001);
        repeat (FUNC_CYCLES - 1) @(posedge clk);
        #1 chk({15'h0000, busy}, 16'h0001);
        @(posedge clk);
        #1 chk({15'h0000, busy}, 16'h0000);
        rd(A_CTRL); chk(q & 16'hCFFF, 16'h0000);
    endtask : t_func
    // Deferred and retained fields across soft then hard reset
    task t_defer();
        wr(A_CTRL, 16'h0612); chk({12'h000, upd}, 16'h0000);
        wr(A_CFG, 16'hC300);
        wr(A_CTRL, 16'h8600);
        chk({15'h0000, srst}, 16'h0001);
        @(posedge clk);
        #1 chk({12'h000, upd}, 16'h0006);
        chk({15'h0000, srst}, 16'h0000);
        chk({8'h00, ret}, 16'h00C3);
        chk({8'h00, rw}, 16'h0001);
        rd(A_CTRL); chk(q & 16'hCFFF, 16'h0601);
        hw_rst(); chk({8'h00, ret}, 16'h0000);
    endtask : t_defer
    task end_sim();
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        nrst = 1'b0; ce = 1'b1; lh = 1'b0; ll = 1'b1; ev = 1'b0;
        hw_rst();
        t_rw(); t_latch(); t_cnt(); t_ce(); t_func(); t_defer();
        end_sim();
    end
    // Whole run is about 66000 cycles
    initial begin
        #400000;
        n_errors++;
        end_sim();
    end
endmodule : rfas_bank_bench
`default_nettype wire
